// File: rclc_chk.sv
// concurrent checks on the register port joining host and device
`timescale 1ns/1ps
module rclc_chk #(
  parameter logic [1:0] SPEED_GRADE = 2'h0
) (
  input wire logic REF_CLK, // block clock
  input wire logic RST, // synchronous reset, active high
  input wire logic req, // port request
  input wire logic wr, // port direction
  input wire logic [7:0] addr, // port address
  input wire logic [7:0] wdata, // port write data
  input wire logic [7:0] rdata, // port read data
  input wire logic ack // port acknowledge
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  sequence rd_ack(a);
    ack && !wr && addr == a;
  endsequence
  sequence srst_wr;
    $rose(req) && wr && addr == rclc_pkg::REG_RST_CAL && wdata[rclc_pkg::BIT_SOFT_RST];
  endsequence
  // the check wants the device deaf for eight cycles of its internal reset, not just one cycle
  sequence deaf;
    !ack [*8];
  endsequence
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("acknowledge held over one cycle");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("acknowledge without request");
  read_answer_a: assert property ($rose(req) && !wr |=> ack)
    else $error("read not answered in one cycle");
  cal_clear_a: assert property (rd_ack(rclc_pkg::REG_RST_CAL) |-> !rdata[6])
    else $error("calibration start bit reads one");
  speed_grade_code_a: assert property (rd_ack(rclc_pkg::REG_RST_CAL) |-> rdata[5:0] == SPEED_GRADE)
    else $error("speed grade field wrong");
  los_hi_a: assert property (rd_ack(rclc_pkg::REG_LOS_HI) |-> rdata[7:1] == 7'h07)
    else $error("upper monitor register fixed bits wrong");
  los_lo_a: assert property (rd_ack(rclc_pkg::REG_LOS_LO) |-> (rdata | 8'h10) == 8'hff)
    else $error("lower monitor register fixed bits wrong");
  srst_quiet_a: assert property (srst_wr |-> ##2 deaf)
    else $error("port answered during soft reset");
endmodule : rclc_chk

// File: rclc_dev.sv
// device end: reset, calibration, speed grade and loss-monitor registers
//
// Implementation choice: the rclc_if register port to the registers; APB is in rclc_host.
`timescale 1ns/1ps
module rclc_dev #(
  parameter int SOFT_RST_CYCLES = rclc_pkg::SOFT_RST_CYC,
  parameter int CAL_CYCLES = 64,
  parameter int LOS_NORM_CNT = 4,
  parameter int LOS_SLOW_CNT = 16,
  parameter logic [1:0] SPEED_GRADE = 2'h0,
  parameter logic [7:0] NVM_REVISION = 8'h00 // arbitrary value
) (
  input wire logic REF_CLK, // block clock
  input wire logic RST, // synchronous reset, active high
  rclc_if.dev PORT, // register port
  input wire logic [31:0] PENDING_DIV, // divider/rate/bandwidth settings written
  input wire logic REF_ACTIVITY, // reference clock activity pin
  output logic [31:0] APPLIED_DIV, // settings in force
  output logic CLK_OUT_EN, // clock outputs enabled
  output logic LOSS_OF_LOCK, // loss of lock alarm
  output logic LOSS_OF_SIGNAL // reference loss alarm
);
  // ---------------------------------------------------------------
  // reset sequencing
  // ---------------------------------------------------------------
  logic [31:0] srst_cnt_ff;
  logic srst_busy_ff;
  logic int_rst;
  logic soft_req;
  logic port_take;
  // a request is taken once, on the edge that raises ack; the host keeps it
  // standing one more cycle while it sees ack, and that cycle must not act again
  assign port_take = PORT.req && !PORT.ack && !srst_busy_ff;
  assign soft_req = port_take && PORT.wr && PORT.addr == rclc_pkg::REG_RST_CAL
                    && PORT.wdata[rclc_pkg::BIT_SOFT_RST];
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      srst_busy_ff <= 1'b0;
      srst_cnt_ff <= '0;
    end else if (soft_req) begin
      srst_busy_ff <= 1'b1;
      srst_cnt_ff <= '0;
    end else if (srst_busy_ff) begin
      srst_cnt_ff <= srst_cnt_ff + 32'h0000_0001;
      if (srst_cnt_ff >= 32'(SOFT_RST_CYCLES - 1)) srst_busy_ff <= 1'b0;
    end
  end
  // internal logic held in reset for the whole soft reset window
  assign int_rst = RST || srst_busy_ff;
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic los_hi_ff;
  logic los_lo_ff;
  logic [1:0] los_mode;
  logic port_wr;
  assign port_wr = port_take && PORT.wr;
  always_ff @(posedge REF_CLK) begin
    if (int_rst) begin
      los_hi_ff <= rclc_pkg::RST_LOS_HI[rclc_pkg::BIT_INPUT_LOSS_MONITOR_ENABLE_HI];
      los_lo_ff <= rclc_pkg::RST_LOS_LO[rclc_pkg::BIT_INPUT_LOSS_MONITOR_ENABLE_LO];
    end else if (port_wr) begin
      if (PORT.addr == rclc_pkg::REG_LOS_HI)
        los_hi_ff <= PORT.wdata[rclc_pkg::BIT_INPUT_LOSS_MONITOR_ENABLE_HI];
      if (PORT.addr == rclc_pkg::REG_LOS_LO)
        los_lo_ff <= PORT.wdata[rclc_pkg::BIT_INPUT_LOSS_MONITOR_ENABLE_LO];
    end
  end
  assign los_mode = {los_hi_ff, los_lo_ff};
  // ---------------------------------------------------------------
  // calibration
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN} rclc_cal_t;
  rclc_cal_t cal_ff;
  logic [15:0] cal_cnt_ff;
  logic lol_ff;
  logic cal_done_once_ff;
  logic cal_req;
  assign cal_req = port_wr && PORT.addr == rclc_pkg::REG_RST_CAL
                   && PORT.wdata[rclc_pkg::BIT_CAL_START]
                   && !PORT.wdata[rclc_pkg::BIT_SOFT_RST];
  logic cal_go;
  logic cal_end;
  assign cal_go = cal_ff == CAL_IDLE && cal_req;
  assign cal_end = cal_ff == CAL_RUN && cal_cnt_ff >= 16'(CAL_CYCLES - 1);
  always_ff @(posedge REF_CLK) begin
    if (int_rst) begin
      cal_ff <= CAL_IDLE;
      cal_cnt_ff <= '0;
    end else begin
      case (cal_ff)
        CAL_IDLE: begin
          if (cal_req) begin
            cal_ff <= CAL_RUN;
            cal_cnt_ff <= '0;
          end
        end
        CAL_RUN: begin
          cal_cnt_ff <= cal_cnt_ff + 16'h0001;
          if (cal_end) cal_ff <= CAL_IDLE;
        end
        default: cal_ff <= CAL_IDLE;
      endcase
    end
  end
  // lock stays lost from the start bit to the end of the sequence, so the
  // host can poll this one alarm to learn when the outputs are usable
  always_ff @(posedge REF_CLK) begin
    if (int_rst) begin
      lol_ff <= 1'b1;
    end else if (cal_go) begin
      lol_ff <= 1'b1;
    end else if (cal_end) begin
      lol_ff <= 1'b0;
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (int_rst) begin
      cal_done_once_ff <= 1'b0;
    end else if (cal_end) begin
      cal_done_once_ff <= 1'b1;
    end
  end
  // new settings are held back until a calibration starts
  always_ff @(posedge REF_CLK) begin
    if (int_rst) begin
      APPLIED_DIV <= '0;
    end else if (cal_go) begin
      APPLIED_DIV <= PENDING_DIV;
    end
  end
  assign LOSS_OF_LOCK = lol_ff;
  assign CLK_OUT_EN = cal_done_once_ff && !srst_busy_ff;
  // ---------------------------------------------------------------
  // loss of signal monitor
  // ---------------------------------------------------------------
  logic act_s1_ff;
  logic act_s2_ff;
  logic act_prev_ff;
  logic [7:0] idle_cnt_ff;
  logic los_ff;
  logic [7:0] limit;
  always_ff @(posedge REF_CLK) begin
    act_s1_ff <= REF_ACTIVITY;
    act_s2_ff <= act_s1_ff;
  end
  // slow mode needs a longer quiet spell before it alarms
  assign limit = (los_mode == rclc_pkg::LOS_SLOW) ? 8'(LOS_SLOW_CNT) : 8'(LOS_NORM_CNT);
  always_ff @(posedge REF_CLK) begin
    if (int_rst) begin
      act_prev_ff <= 1'b0;
      idle_cnt_ff <= '0;
      los_ff <= 1'b0;
    end else begin
      act_prev_ff <= act_s2_ff;
      if (los_mode != rclc_pkg::LOS_NORM && los_mode != rclc_pkg::LOS_SLOW) begin
        idle_cnt_ff <= '0;
        los_ff <= 1'b0;
      end else if (act_prev_ff != act_s2_ff) begin
        idle_cnt_ff <= '0;
        los_ff <= 1'b0;
      end else if (idle_cnt_ff >= limit) begin
        los_ff <= 1'b1;
      end else begin
        idle_cnt_ff <= idle_cnt_ff + 8'h01;
      end
    end
  end
  assign LOSS_OF_SIGNAL = los_ff;
  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] nxt_rdata;
  // reserved bits read back their reset pattern; only the live bits vary
  always_comb begin
    case (PORT.addr)
      // start and reset bits always read 0: both clear themselves
      rclc_pkg::REG_RST_CAL:
        nxt_rdata = {rclc_pkg::RST_RST_CAL[7:2], SPEED_GRADE};
      rclc_pkg::REG_LOS_HI:
        nxt_rdata = {rclc_pkg::RST_LOS_HI[7:1], los_hi_ff};
      rclc_pkg::REG_LOS_LO:
        nxt_rdata = {rclc_pkg::RST_LOS_LO[7:5], los_lo_ff, rclc_pkg::RST_LOS_LO[3:0]};
      rclc_pkg::REG_NVM_REV: nxt_rdata = NVM_REVISION;
      default: nxt_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge REF_CLK) begin
    if (int_rst) begin
      PORT.rdata <= '0;
      PORT.ack <= 1'b0;
    end else begin
      PORT.ack <= port_take;
      PORT.rdata <= nxt_rdata;
    end
  end
endmodule : rclc_dev

// File: rclc_host.sv
// host end: APB command registers driving the device register port
`timescale 1ns/1ps
module rclc_host #(
  parameter int SOFT_RST_CYCLES = rclc_pkg::SOFT_RST_CYC
) (
  input wire logic REF_CLK, // block clock
  input wire logic RST, // synchronous reset, active high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  input wire logic DEV_LOL, // device loss of lock alarm
  rclc_if.host PORT // register port
);
  typedef enum logic [2:0] {H_IDLE, H_REQ, H_WAIT, H_CALW} rclc_hst_t;
  rclc_hst_t st_ff;
  logic [7:0] addr_ff;
  logic [7:0] wdat_ff;
  logic [7:0] rdat_ff;
  logic wr_ff;
  logic cal_ff;
  logic busy;
  logic [31:0] hold_ff;
  logic apb_wr;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign busy = st_ff != H_IDLE || hold_ff != 32'h0000_0000;
  // ---------------------------------------------------------------
  // command sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_ff <= H_IDLE;
      addr_ff <= '0;
      wdat_ff <= '0;
      rdat_ff <= '0;
      wr_ff <= 1'b0;
      cal_ff <= 1'b0;
      hold_ff <= '0;
    end else begin
      if (hold_ff != 32'h0000_0000) hold_ff <= hold_ff - 32'h0000_0001;
      case (st_ff)
        H_IDLE: begin
          if (apb_wr && PADDR == rclc_pkg::APB_WDATA) wdat_ff <= PWDATA[7:0];
          if (apb_wr && PADDR == rclc_pkg::APB_CMD && PWDATA[rclc_pkg::CMD_GO] && !busy) begin
            addr_ff <= PWDATA[7:0];
            wr_ff <= PWDATA[rclc_pkg::CMD_WR];
            cal_ff <= 1'b0;
            st_ff <= H_REQ;
            if (PWDATA[rclc_pkg::CMD_SRST]) begin
              addr_ff <= rclc_pkg::REG_RST_CAL;
              wdat_ff <= 8'(1 << rclc_pkg::BIT_SOFT_RST);
              wr_ff <= 1'b1;
            end else if (PWDATA[rclc_pkg::CMD_CAL]) begin
              // caller must have a stable reference and legal dividers first
              addr_ff <= rclc_pkg::REG_RST_CAL;
              wdat_ff <= 8'(1 << rclc_pkg::BIT_CAL_START);
              wr_ff <= 1'b1;
              cal_ff <= 1'b1;
            end
          end
        end
        H_REQ: st_ff <= H_WAIT;
        H_WAIT: begin
          if (PORT.ack) begin
            rdat_ff <= PORT.rdata;
            st_ff <= cal_ff ? H_CALW : H_IDLE;
            if (wr_ff && addr_ff == rclc_pkg::REG_RST_CAL && wdat_ff[rclc_pkg::BIT_SOFT_RST])
              hold_ff <= 32'(SOFT_RST_CYCLES);
          end
        end
        H_CALW: begin
          if (!DEV_LOL) st_ff <= H_IDLE;
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end
  // the soft reset write is still acked; the hold timer then keeps the port quiet
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PORT.req <= 1'b0;
    end else begin
      PORT.req <= st_ff == H_REQ || (st_ff == H_WAIT && !PORT.ack);
    end
  end
  assign PORT.wr = wr_ff;
  assign PORT.addr = addr_ff;
  assign PORT.wdata = wdat_ff;
  // ---------------------------------------------------------------
  // apb read
  // ---------------------------------------------------------------
  logic [31:0] nxt_prdata;
  always_comb begin
    case (PADDR)
      rclc_pkg::APB_WDATA: nxt_prdata = {24'h00_0000, wdat_ff};
      rclc_pkg::APB_RDATA: nxt_prdata = {24'h00_0000, rdat_ff};
      rclc_pkg::APB_STAT: nxt_prdata = {29'h0000_0000, DEV_LOL, hold_ff != 32'h0, busy};
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end
  // captured in the setup cycle, so the word stands through the access cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= nxt_prdata;
    end
  end
endmodule : rclc_host

// File: rclc_if.sv
// register port joining host controller and device register bank
`timescale 1ns/1ps
interface rclc_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport host (output req, output wr, output addr, output wdata, input rdata, input ack);
  modport dev (input req, input wr, input addr, input wdata, output rdata, output ack);
endinterface : rclc_if

// File: rclc_pkg.sv
// shared constants for the reset, calibration and loss-monitor register bank
package rclc_pkg;
  // ---------------------------------------------------------------
  // register offsets on the device register port
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RST_CAL = 8'h88;
  localparam logic [7:0] REG_LOS_HI = 8'h8a;
  localparam logic [7:0] REG_LOS_LO = 8'h8b;
  localparam logic [7:0] REG_NVM_REV = 8'hb9;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int BIT_SOFT_RST = 7;
  localparam int BIT_CAL_START = 6;
  localparam int BIT_INPUT_LOSS_MONITOR_ENABLE_HI = 0;
  localparam int BIT_INPUT_LOSS_MONITOR_ENABLE_LO = 4;
  localparam logic [7:0] RST_RST_CAL = 8'h00;
  localparam logic [7:0] RST_LOS_HI = 8'h0f;
  localparam logic [7:0] RST_LOS_LO = 8'hff;
  // ---------------------------------------------------------------
  // loss monitor modes
  // ---------------------------------------------------------------
  localparam logic [1:0] LOS_OFF = 2'h0;
  localparam logic [1:0] LOS_SLOW = 2'h2;
  localparam logic [1:0] LOS_NORM = 2'h3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SOFT_RST_MS = 10;
  localparam int SOFT_RST_CYC = SOFT_RST_MS * (CLK_HZ / 1000);
  // host status / command register byte offsets (APB)
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_WDATA = 8'h04;
  localparam logic [7:0] APB_RDATA = 8'h08;
  localparam logic [7:0] APB_STAT = 8'h0c;
  localparam int CMD_GO = 31;
  localparam int CMD_WR = 30;
  localparam int CMD_CAL = 29;
  localparam int CMD_SRST = 28;
endpackage : rclc_pkg

// File: test_reset_calibration_los_control.sv
// self-checking bench: host and device joined on the register port
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_reset_calibration_los_control;
  localparam logic [1:0] GRADE = 2'h2;
  localparam logic [7:0] REV = 8'h5a; // arbitrary value
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic REF_ACTIVITY = 1'b0;
  logic ref_on = 1'b1;
  logic PREADY, PSLVERR, CLK_OUT_EN, LOSS_OF_LOCK, LOSS_OF_SIGNAL, perr;
  logic [7:0] PADDR = 8'h00;
  logic [7:0] rv;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PENDING_DIV = 32'h0000_0000;
  logic [31:0] PRDATA, APPLIED_DIV, prd;
  logic [1:0] modes [4] = '{rclc_pkg::LOS_OFF, 2'h1, rclc_pkg::LOS_SLOW, rclc_pkg::LOS_NORM};
  int bad_count = 0;
  int cmp_count = 0;
  rclc_if port ();
  rclc_host #(.SOFT_RST_CYCLES(20)) i_rclc_host (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .DEV_LOL(LOSS_OF_LOCK), .PORT(port.host));
  rclc_dev #(.SOFT_RST_CYCLES(20), .CAL_CYCLES(8), .SPEED_GRADE(GRADE), .NVM_REVISION(REV))
    i_rclc_dev (.REF_CLK(REF_CLK), .RST(RST), .PORT(port.dev), .PENDING_DIV(PENDING_DIV),
    .REF_ACTIVITY(REF_ACTIVITY), .APPLIED_DIV(APPLIED_DIV), .CLK_OUT_EN(CLK_OUT_EN),
    .LOSS_OF_LOCK(LOSS_OF_LOCK), .LOSS_OF_SIGNAL(LOSS_OF_SIGNAL));
  rclc_chk #(.SPEED_GRADE(GRADE)) i_rclc_chk (.REF_CLK(REF_CLK), .RST(RST), .req(port.req),
    .wr(port.wr), .addr(port.addr), .wdata(port.wdata), .rdata(port.rdata), .ack(port.ack));
  initial forever #50 REF_CLK = ~REF_CLK;
  // reference toggles while present; held still it models a lost input
  always @(posedge REF_CLK) if (ref_on) REF_ACTIVITY <= ~REF_ACTIVITY;
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic hang();
    bad_count++;
    print_verdict();
  endtask : hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge REF_CLK);
      if (PREADY === 1'b1) break;
    end
    prd = PRDATA;
    perr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n == 64) hang();
  endtask : apb
  // polls busy and the soft reset hold; the host itself keeps the port quiet
  task automatic wait_idle();
    int n;
    for (n = 0; n < 200; n++) begin
      apb(1'b0, rclc_pkg::APB_STAT, 32'h0000_0000);
      if (prd[1:0] === 2'b00) break;
    end
    if (n == 200) hang();
  endtask : wait_idle
  task automatic dev_op(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, rclc_pkg::APB_WDATA, {24'h00_0000, d});
    apb(1'b1, rclc_pkg::APB_CMD, {1'b1, w, 22'h00_0000, a});
    wait_idle();
    apb(1'b0, rclc_pkg::APB_RDATA, 32'h0000_0000);
    rv = prd[7:0];
  endtask : dev_op
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    int n;
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    `CHK(LOSS_OF_LOCK, 1'b1)
    dev_op(1'b0, rclc_pkg::REG_RST_CAL, 8'h00);
    `CHK(rv, {6'h00, GRADE})
    dev_op(1'b0, rclc_pkg::REG_LOS_HI, 8'h00);
    `CHK(rv, rclc_pkg::RST_LOS_HI)
    dev_op(1'b0, rclc_pkg::REG_LOS_LO, 8'h00);
    `CHK(rv, rclc_pkg::RST_LOS_LO)
    dev_op(1'b0, rclc_pkg::REG_NVM_REV, 8'h00);
    `CHK(rv, REV)
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK(perr, 1'b0)
    $display("test defaults done");
    `CHK(CLK_OUT_EN, 1'b0)
    PENDING_DIV <= 32'h1234_5678;
    dev_op(1'b1, rclc_pkg::REG_RST_CAL, 8'h40);
    dev_op(1'b0, rclc_pkg::REG_RST_CAL, 8'h00);
    `CHK(rv, {6'h00, GRADE})
    for (n = 0; n < 40 && LOSS_OF_LOCK !== 1'b0; n++) @(posedge REF_CLK);
    `CHK(LOSS_OF_LOCK, 1'b0)
    `CHK(APPLIED_DIV, 32'h1234_5678)
    `CHK(CLK_OUT_EN, 1'b1)
    PENDING_DIV <= 32'h0bad_0001;
    apb(1'b0, rclc_pkg::APB_STAT, 32'h0000_0000);
    `CHK(prd[2], 1'b0)
    `CHK(APPLIED_DIV, 32'h1234_5678)
    apb(1'b1, rclc_pkg::APB_CMD, 32'ha000_0000);
    apb(1'b0, rclc_pkg::APB_STAT, 32'h0000_0000);
    `CHK(prd[0], 1'b1)
    apb(1'b0, rclc_pkg::APB_STAT, 32'h0000_0000);
    `CHK(prd[2], 1'b1)
    `CHK(prd[0], 1'b1)
    wait_idle();
    `CHK(LOSS_OF_LOCK, 1'b0)
    `CHK(APPLIED_DIV, 32'h0bad_0001)
    $display("test calibration done");
    for (n = 0; n < 4; n++) begin
      ref_on <= 1'b1;
      dev_op(1'b1, rclc_pkg::REG_LOS_HI, {7'h00, modes[n][1]});
      dev_op(1'b1, rclc_pkg::REG_LOS_LO, {3'h0, modes[n][0], 4'h0});
      dev_op(1'b0, rclc_pkg::REG_LOS_LO, 8'h00);
      `CHK(rv, {3'h7, modes[n][0], 4'hf})
      dev_op(1'b0, rclc_pkg::REG_LOS_HI, 8'h00);
      `CHK(rv, {7'h07, modes[n][1]})
      repeat (30) @(posedge REF_CLK);
      `CHK(LOSS_OF_SIGNAL, 1'b0)
      ref_on <= 1'b0;
      repeat (12) @(posedge REF_CLK);
      `CHK(LOSS_OF_SIGNAL, modes[n] === rclc_pkg::LOS_NORM)
      repeat (20) @(posedge REF_CLK);
      `CHK(LOSS_OF_SIGNAL, modes[n][1])
    end
    $display("test loss monitor done");
    dev_op(1'b1, rclc_pkg::REG_LOS_LO, 8'h00);
    apb(1'b1, rclc_pkg::APB_WDATA, 32'h0000_0080);
    apb(1'b1, rclc_pkg::APB_CMD, 32'hc000_0088);
    apb(1'b0, rclc_pkg::APB_STAT, 32'h0000_0000);
    `CHK(prd[0], 1'b1)
    apb(1'b0, rclc_pkg::APB_STAT, 32'h0000_0000);
    `CHK(prd[1], 1'b1)
    `CHK(CLK_OUT_EN, 1'b0)
    `CHK(LOSS_OF_LOCK, 1'b1)
    wait_idle();
    dev_op(1'b0, rclc_pkg::REG_LOS_LO, 8'h00);
    `CHK(rv, rclc_pkg::RST_LOS_LO)
    $display("test soft reset done");
    print_verdict();
  end
endmodule : test_reset_calibration_los_control
